// >>> design/cetc_defs.vh
`ifndef CETC_DEFS_VH
`define CETC_DEFS_VH

// ==========================================================================
// Register byte addresses.
`define CETC_ADDR_CFG 8'h08
`define CETC_ADDR_RL_LOW 8'h0C
`define CETC_ADDR_RL_MID 8'h10
`define CETC_ADDR_RL_HIGH 8'h14
`define CETC_ADDR_STATUS 8'h18
`define CETC_ADDR_MASK 8'h1C
`define CETC_ADDR_ETU_DIV 8'h20

// ==========================================================================
// Status and mask bit positions.
`define CETC_BIT_LOW_EXP 0
`define CETC_BIT_WIDE_EXP 1
`define CETC_BIT_LOW_RUN 4
`define CETC_BIT_WIDE_RUN 5

// ==========================================================================
// Configuration codes.
`define CETC_CODE_STOP 8'h00
`define CETC_CODE_05 8'h05
`define CETC_CODE_65 8'h65
`define CETC_CODE_71 8'h71
`define CETC_CODE_75 8'h75
`define CETC_CODE_7C 8'h7C
`define CETC_CODE_85 8'h85
`define CETC_CODE_E5 8'hE5
`define CETC_CODE_F1 8'hF1
`define CETC_CODE_F5 8'hF5

// ==========================================================================
// Reset values and timing counts.
`define CETC_RST_CFG 8'h00
`define CETC_RST_RELOAD 8'h00
`define CETC_RST_MASK 2'h0
`define CETC_RST_ETU_DIV 16'h0174
`define CETC_CUT_ETU 4'hC
`define CETC_FRAME_ETU 4'hA

`endif

// >>> design/cetc_etu_gen.v
`timescale 1ns/1ps
`include "cetc_defs.vh"

module cetc_etu_gen (
    // Clock and reset.
    input wire i_mclk,
    input wire i_rstn,
    // Clocks per elementary time unit.
    input wire [15:0] i_div,
    // Card line.
    input wire i_card_io,
    input wire i_card_tx,
    // Events.
    output wire o_start,
    output wire o_start_rx,
    output wire o_tick
);

    // ======================================================================
    // Start-bit detection.
    // Falling edges inside a character are data, not start-bits, so the
    // detector is blanked for one character frame after each start.
    reg io_prev_q;
    reg [3:0] blank_q;
    reg [15:0] ph_q;
    wire [15:0] div_m1;

    assign o_start = io_prev_q & ~i_card_io & (blank_q == 4'h0);
    assign o_start_rx = o_start & ~i_card_tx;

    // ======================================================================
    // ETU tick, phase aligned to the last start-bit.
    assign div_m1 = (i_div == 16'h0000) ? 16'h0000 : i_div - 16'h0001;
    assign o_tick = ~o_start & (ph_q >= div_m1);

    always @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            io_prev_q <= 1'b1;
            blank_q <= 4'h0;
            ph_q <= 16'h0000;
        end else begin
            io_prev_q <= i_card_io;
            if (o_start) begin
                blank_q <= `CETC_FRAME_ETU;
                ph_q <= 16'h0000;
            end else if (o_tick) begin
                ph_q <= 16'h0000;
                if (blank_q != 4'h0) begin
                    blank_q <= blank_q - 4'h1;
                end
            end else begin
                ph_q <= ph_q + 16'h0001;
            end
        end
    end

endmodule // cetc_etu_gen

// >>> design/cetc_top.v
// What this block does
// RULE_01 - Code 75: 8-bit reload plus 16-bit counter.
// RULE_02 - Code 75: low starts at first start-bit.
// RULE_03 - Low expiry: interrupt, flag, automatic restart.
// RULE_04 - Software keeps low reload steady while counting.
// RULE_05 - Code 75: wide counter starts, restarts per start-bit.
// RULE_06 - New reloads apply only at next start-bit.
// RULE_07 - Writing 00h stops all counters.
// RULE_08 - Software avoids all-zero reloads in retrigger modes.
// RULE_09 - Code 7C: one 24-bit retriggered counter.
// RULE_10 - Code 85: like 05, stop 12 ETU after receive.
// RULE_11 - Code E5: like 65, low stops after 12 ETU.
// RULE_12 - Code F1: like 71, wide stops after 12 ETU.
// RULE_13 - Code F5: like 75, both stop after 12 ETU.
// RULE_14 - Code 05: only low counter runs, auto-reload.
// RULE_15 - Code 65: wide starts on write, expiry flags.
// RULE_16 - Code 71: low stopped, wide retriggered by start-bits.
// RULE_17 - Configuration register read/write at address 8h.
// RULE_18 - Counters advance once per ETU.
// RULE_19 - Retriggered wide expiry raises interrupt and flag.
`timescale 1ns/1ps
`include "cetc_defs.vh"

module cetc_top #(
    parameter [15:0] ETU_DIV_RST = `CETC_RST_ETU_DIV
) (
    // Clock and reset.
    input wire i_mclk,
    input wire i_rstn,
    // APB slave.
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [7:0] i_paddr,
    input wire [31:0] i_pwdata,
    output wire [31:0] o_prdata,
    output wire o_pready,
    output wire o_pslverr,
    // Card line.
    input wire i_card_io,
    input wire i_card_tx,
    // Interrupt.
    output wire o_irq
);

    // ======================================================================
    // Mode decode.
    // Bits: 0 low used, 1 low starts on write, 2 wide starts on write,
    // 3 wide retriggered, 4 joined 24-bit, 5 cut low, 6 cut wide,
    // 7 cut waits for a received start-bit.
    function [7:0] mode_bits;
        input [7:0] c;
        begin
            case (c)
                `CETC_CODE_05: mode_bits = 8'b0000_0011;
                `CETC_CODE_85: mode_bits = 8'b1110_0011;
                `CETC_CODE_65: mode_bits = 8'b0000_0101;
                `CETC_CODE_E5: mode_bits = 8'b0010_0101;
                `CETC_CODE_71: mode_bits = 8'b0000_1000;
                `CETC_CODE_F1: mode_bits = 8'b0100_1000;
                `CETC_CODE_75: mode_bits = 8'b0000_1001;
                `CETC_CODE_F5: mode_bits = 8'b0110_1001;
                `CETC_CODE_7C: mode_bits = 8'b0001_0000;
                default: mode_bits = 8'b0000_0000;
            endcase
        end
    endfunction

    localparam [3:0] CUT_IDLE = 4'b0001;
    localparam [3:0] CUT_ARM = 4'b0010;
    localparam [3:0] CUT_RUN = 4'b0100;
    localparam [3:0] CUT_DONE = 4'b1000;

    // ======================================================================
    // Declarations.
    reg [7:0] cfg_q;
    reg [7:0] rl_low_q;
    reg [7:0] rl_mid_q;
    reg [7:0] rl_high_q;
    reg [1:0] sts_q;
    reg [1:0] msk_q;
    reg [15:0] div_q;
    reg [31:0] prdata_q;
    reg [7:0] cnt_low_q;
    reg [15:0] cnt_wide_q;
    reg low_run_q;
    reg low_arm_q;
    reg wide_run_q;
    reg [3:0] cut_st_q;
    reg [3:0] cut_cnt_q;
    reg [31:0] rd_mux;
    wire setup;
    wire access;
    wire wr;
    wire rd;
    wire hit_cfg;
    wire hit_low;
    wire hit_mid;
    wire hit_high;
    wire hit_sts;
    wire hit_msk;
    wire hit_div;
    wire map_ok;
    wire cfg_wr;
    wire [7:0] mw;
    wire [7:0] mc;
    wire start;
    wire start_rx;
    wire tick;
    wire cut_start;
    wire cut_stop;
    wire [23:0] cnt24;
    wire low_exp;
    wire wide_exp;
    wire [1:0] sts_set;
    wire [1:0] sts_clr;

    // ======================================================================
    // APB decode.
    assign setup = i_psel & ~i_penable;
    assign access = i_psel & i_penable;
    assign wr = access & i_pwrite;
    assign rd = access & ~i_pwrite;
    assign hit_cfg = (i_paddr == `CETC_ADDR_CFG); // see RULE_17
    assign hit_low = (i_paddr == `CETC_ADDR_RL_LOW);
    assign hit_mid = (i_paddr == `CETC_ADDR_RL_MID);
    assign hit_high = (i_paddr == `CETC_ADDR_RL_HIGH);
    assign hit_sts = (i_paddr == `CETC_ADDR_STATUS);
    assign hit_msk = (i_paddr == `CETC_ADDR_MASK);
    assign hit_div = (i_paddr == `CETC_ADDR_ETU_DIV);
    assign map_ok = hit_cfg | hit_low | hit_mid | hit_high | hit_sts |
                    hit_msk | hit_div;
    assign cfg_wr = wr & hit_cfg;
    assign o_pready = access;
    assign o_pslverr = access & ~map_ok;
    assign o_prdata = prdata_q;

    always @* begin
        rd_mux = 32'h0000_0000;
        case (1'b1)
            hit_cfg: rd_mux[7:0] = cfg_q; // see RULE_17
            hit_low: rd_mux[7:0] = rl_low_q;
            hit_mid: rd_mux[7:0] = rl_mid_q;
            hit_high: rd_mux[7:0] = rl_high_q;
            hit_sts: begin
                rd_mux[1:0] = sts_q;
                rd_mux[`CETC_BIT_LOW_RUN] = low_run_q;
                rd_mux[`CETC_BIT_WIDE_RUN] = wide_run_q;
            end
            hit_msk: rd_mux[1:0] = msk_q;
            hit_div: rd_mux[15:0] = div_q;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // ======================================================================
    // Register file.
    // Read data is captured in the setup cycle, so a read-clear only
    // clears the flags that software actually saw; a flag set later is
    // kept for the next read.
    assign sts_set = {wide_exp, low_exp};
    assign sts_clr = (rd & hit_sts) ? prdata_q[1:0] : 2'b00;

    always @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            cfg_q <= `CETC_RST_CFG;
            rl_low_q <= `CETC_RST_RELOAD;
            rl_mid_q <= `CETC_RST_RELOAD;
            rl_high_q <= `CETC_RST_RELOAD;
            msk_q <= `CETC_RST_MASK;
            div_q <= ETU_DIV_RST;
            sts_q <= 2'b00;
            prdata_q <= 32'h0000_0000;
        end else begin
            if (setup) begin
                prdata_q <= rd_mux;
            end
            if (cfg_wr) begin
                cfg_q <= i_pwdata[7:0]; // see RULE_17
            end
            if (wr & hit_low) begin
                rl_low_q <= i_pwdata[7:0]; // see RULE_04
            end
            if (wr & hit_mid) begin
                rl_mid_q <= i_pwdata[7:0];
            end
            if (wr & hit_high) begin
                rl_high_q <= i_pwdata[7:0];
            end
            if (wr & hit_msk) begin
                msk_q <= i_pwdata[1:0];
            end
            if (wr & hit_div) begin
                div_q <= i_pwdata[15:0];
            end
            sts_q <= (sts_q & ~sts_clr) | sts_set; // see RULE_03, RULE_15
        end
    end

    assign o_irq = |(sts_q & msk_q);

    // ======================================================================
    // ETU timing and start-bit events.
    cetc_etu_gen u_etu (
        .i_mclk(i_mclk),
        .i_rstn(i_rstn),
        .i_div(div_q),
        .i_card_io(i_card_io),
        .i_card_tx(i_card_tx),
        .o_start(start),
        .o_start_rx(start_rx),
        .o_tick(tick)
    );

    // ======================================================================
    // Counters.
    assign mw = mode_bits(i_pwdata[7:0]);
    assign mc = mode_bits(cfg_q);
    assign cnt24 = {cnt_wide_q, cnt_low_q};
    assign cut_start = (cut_st_q == CUT_ARM) &
                       (mc[7] ? start_rx : start); // see RULE_10
    assign cut_stop = (cut_st_q == CUT_RUN) & tick &
                      (cut_cnt_q == `CETC_CUT_ETU - 4'h1);
    assign low_exp = ~cfg_wr & tick & low_run_q & ~mc[4] &
                     (cnt_low_q <= 8'h01); // see RULE_03
    assign wide_exp = ~cfg_wr & tick & wide_run_q &
                      (mc[4] ? (cnt24 <= 24'h00_0001) :
                       (cnt_wide_q <= 16'h0001)); // see RULE_15, RULE_19

    always @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt_low_q <= 8'h00;
            cnt_wide_q <= 16'h0000;
            low_run_q <= 1'b0;
            low_arm_q <= 1'b0;
            wide_run_q <= 1'b0;
            cut_st_q <= CUT_IDLE;
            cut_cnt_q <= 4'h0;
        end else if (cfg_wr) begin
            // A code of 00h or any unlisted code decodes to all zero.
            low_run_q <= mw[0] & mw[1]; // see RULE_07, RULE_14, RULE_10
            low_arm_q <= mw[0] & ~mw[1]; // see RULE_02
            cnt_low_q <= rl_low_q;
            wide_run_q <= mw[2]; // see RULE_07, RULE_15, RULE_16
            cnt_wide_q <= {rl_high_q, rl_mid_q};
            cut_cnt_q <= 4'h0;
            cut_st_q <= (mw[5] | mw[6]) ? CUT_ARM : CUT_IDLE;
        end else begin
            case (cut_st_q)
                CUT_IDLE: cut_st_q <= CUT_IDLE;
                CUT_ARM: begin
                    if (cut_start) begin
                        cut_st_q <= CUT_RUN;
                        cut_cnt_q <= 4'h0;
                    end
                end
                CUT_RUN: begin
                    if (cut_stop) begin
                        cut_st_q <= CUT_DONE; // see RULE_11, RULE_12, RULE_13
                    end else if (tick) begin
                        cut_cnt_q <= cut_cnt_q + 4'h1;
                    end
                end
                CUT_DONE: cut_st_q <= CUT_DONE;
                default: cut_st_q <= CUT_IDLE;
            endcase
            if (start & (cut_st_q != CUT_DONE)) begin
                // Apart from a configuration write and a low expiry, reloads are sampled
                // only here, so in the retriggered modes a wide reload written mid-count waits for the next start-bit.
                if (low_arm_q) begin
                    low_arm_q <= 1'b0;
                    low_run_q <= 1'b1; // see RULE_02
                    cnt_low_q <= rl_low_q;
                end
                if (mc[3]) begin
                    wide_run_q <= 1'b1; // see RULE_05, RULE_16, RULE_08
                    cnt_wide_q <= {rl_high_q, rl_mid_q}; // see RULE_06
                end
                if (mc[4]) begin
                    wide_run_q <= 1'b1; // see RULE_09, RULE_08
                    cnt_wide_q <= {rl_high_q, rl_mid_q}; // see RULE_06
                    cnt_low_q <= rl_low_q;
                end
            end else if (tick) begin
                if (low_run_q & ~mc[4]) begin
                    if (low_exp) begin
                        cnt_low_q <= rl_low_q; // see RULE_03, RULE_01
                    end else begin
                        cnt_low_q <= cnt_low_q - 8'h01; // see RULE_18
                    end
                end
                if (wide_run_q & ~mc[4]) begin
                    if (wide_exp) begin
                        wide_run_q <= 1'b0; // see RULE_15, RULE_19
                    end else begin
                        cnt_wide_q <= cnt_wide_q - 16'h0001; // see RULE_01
                    end
                end
                if (wide_run_q & mc[4]) begin
                    if (wide_exp) begin
                        wide_run_q <= 1'b0; // see RULE_19
                    end else begin
                        {cnt_wide_q, cnt_low_q} <= cnt24 - 24'h00_0001;
                    end
                end
            end
            // The cut tick still advances a counter that the cut spares,
            // so the stop is applied last and wins for the others.
            if (cut_stop) begin
                if (mc[5]) begin
                    low_run_q <= 1'b0; // see RULE_10, RULE_11, RULE_13
                    low_arm_q <= 1'b0;
                end
                if (mc[6]) begin
                    wide_run_q <= 1'b0; // see RULE_12, RULE_13
                end
            end
        end
    end

endmodule // cetc_top

// >>> testbench/cetc_card_model.sv
`timescale 1ns/1ps

module cetc_card_model (
    // Clock.
    input wire i_mclk,
    // Card line, idle high through its pull-up.
    output logic o_card_io = 1'b1,
    output logic o_card_tx = 1'b0
);
    // ======================================================================
    // One character: start bit, eight data bits, even parity, guard time.
    task automatic frame(input int div, input logic tx, input logic [7:0] d);
        logic [9:0] bits;
        bits = {^d, d, 1'b0};
        o_card_tx <= tx;
        for (int i = 0; i < 10; i++) begin
            repeat (div) begin
                @(posedge i_mclk);
                o_card_io <= bits[i];
            end
        end
        repeat (2 * div) begin
            @(posedge i_mclk);
            o_card_io <= 1'b1;
        end
        o_card_tx <= 1'b0;
    endtask
endmodule // cetc_card_model

// >>> testbench/cetc_top_assertions.sv
`timescale 1ns/1ps
`include "cetc_defs.vh"

module cetc_top_assertions (
    // Clock and reset.
    input wire i_mclk,
    input wire i_rstn,
    // APB slave.
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [7:0] i_paddr,
    input wire [31:0] i_pwdata,
    input wire [31:0] o_prdata,
    input wire o_pready,
    input wire o_pslverr,
    // Card line and interrupt.
    input wire i_card_io,
    input wire i_card_tx,
    input wire o_irq
);
    // ======================================================================
    // Helper state.
    wire acc = i_psel & i_penable;
    wire rd = acc & ~i_pwrite;
    wire mapped = i_paddr[1:0] == 2'h0 && i_paddr >= 8'h08 && i_paddr <= 8'h20;
    reg mask_off_q;
    reg cfg_off_q;
    always @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            mask_off_q <= 1'b1;
            cfg_off_q <= 1'b1;
        end else if (acc & i_pwrite) begin
            if (i_paddr == `CETC_ADDR_MASK)
                mask_off_q <= i_pwdata[1:0] == 2'h0;
            if (i_paddr == `CETC_ADDR_CFG)
                cfg_off_q <= i_pwdata[7:0] == 8'h00;
        end
    end
    // ======================================================================
    // Properties.
    default clocking dc @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);
    a_ready_access: assert property (acc |-> o_pready)
        else $error("pready low in access");
    a_ready_idle: assert property (!acc |-> !o_pready)
        else $error("pready high outside access");
    a_err_unmapped: assert property (
        acc && !mapped |-> o_pslverr)
        else $error("no pslverr on unmapped address");
    a_err_mapped: assert property (acc && mapped |-> !o_pslverr)
        else $error("pslverr on mapped address");
    a_unmapped_zero: assert property (
        rd && !mapped |-> o_prdata == 0)
        else $error("unmapped read not zero");
    a_data_held: assert property (rd |=> $stable(o_prdata))
        else $error("read data moved after access");
    a_cfg_width: assert property (
        rd && i_paddr inside {8'h08, 8'h0C, 8'h10, 8'h14} |->
        o_prdata[31:8] == 0)
        else $error("byte register upper bits set");
    a_irq_masked: assert property (mask_off_q |-> !o_irq)
        else $error("interrupt with all sources masked");
    a_stop_idle: assert property (
        cfg_off_q && rd && i_paddr == `CETC_ADDR_STATUS |->
        o_prdata[5:4] == 2'h0)
        else $error("counter running after stop code");
endmodule // cetc_top_assertions

bind cetc_top cetc_top_assertions cetc_top_assertions_i (
    .i_mclk(i_mclk), .i_rstn(i_rstn), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .i_card_io(i_card_io), .i_card_tx(i_card_tx),
    .o_irq(o_irq));

// >>> testbench/cetc_top_tb.sv
`timescale 1ns/1ps
`include "cetc_defs.vh"

module cetc_top_tb;
    logic i_mclk = 1'b0;
    logic i_rstn = 1'b0;
    logic i_psel = 1'b0;
    logic i_penable = 1'b0;
    logic i_pwrite = 1'b0;
    logic [7:0] i_paddr = 8'h00;
    logic [31:0] i_pwdata = 32'h0000_0000;
    wire [31:0] o_prdata;
    wire o_pready, o_pslverr, o_irq, io, tx;
    int error_cnt = 0, comparisons = 0, cyc = 0, t, n, mid;
    logic [31:0] seed = 32'h1305_909d, r, v;
    logic err;
    logic [7:0] codes [9] = '{8'h05, 8'h65, 8'h71, 8'h75, 8'h85, 8'hE5,
        8'hF1, 8'hF5, 8'h7C};

    always #10 i_mclk = ~i_mclk;

    cetc_top cetc_top_i (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
        .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
        .o_pslverr(o_pslverr), .i_card_io(io), .i_card_tx(tx),
        .o_irq(o_irq));
    cetc_card_model cetc_card_model_i (.i_mclk(i_mclk), .o_card_io(io),
        .o_card_tx(tx));

    // ======================================================================
    // Helpers.
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Reference flags after a start-bit and a 30-ETU wait.
    function automatic logic [31:0] model(input logic [7:0] c, input int lo,
        input int wd);
        logic lr, lc, wr, wc;
        lr = c inside {8'h05, 8'h85, 8'h65, 8'hE5, 8'h75, 8'hF5};
        lc = c inside {8'h85, 8'hE5, 8'hF5};
        wr = c inside {8'h65, 8'hE5, 8'h71, 8'hF1, 8'h75, 8'hF5, 8'h7C};
        wc = c inside {8'hF1, 8'hF5};
        if (c == 8'h7C)
            wd = wd * 256 + lo;
        return {wr && wd <= (wc ? 12 : 30), lr && lo <= (lc ? 12 : 30)};
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // The request is held until pready is seen high at a rising edge.
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge i_mclk);
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_mclk);
        i_penable <= 1'b1;
        do begin
            @(posedge i_mclk);
        end while (o_pready !== 1'b1);
        r = o_prdata;
        err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask

    task automatic wait_irq();
        // At least one edge passes, since a flag cleared by a read at this
        // edge still shows on the pin until the clear lands.
        n = 0;
        do begin
            @(posedge i_mclk);
            n++;
        end while (o_irq !== 1'b1 && n < 400);
    endtask

    always @(posedge i_mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            chk(32'h0000_0000, 32'h0000_0001);
            test_done();
        end
    end

    // ======================================================================
    // Sequence.
    initial begin
        repeat (16) @(posedge i_mclk);
        i_rstn <= 1'b1;
        apb(0, `CETC_ADDR_CFG, 0); chk(r, 0);
        apb(0, `CETC_ADDR_ETU_DIV, 0); chk(r, 32'h0000_0174);
        apb(0, `CETC_ADDR_MASK, 0); chk(r, 0);
        apb(1, 8'h40, 32'hFFFF_FFFF); chk({r[30:0], err}, 1);
        for (int i = 0; i < 6; i++) begin
            v = xs() & 32'h0000_00FF;
            apb(1, `CETC_ADDR_CFG, v);
            apb(0, `CETC_ADDR_CFG, 0); chk(r, v);
        end
        apb(1, `CETC_ADDR_CFG, 0);
        apb(0, `CETC_ADDR_STATUS, 0);
        $display("register test done");
        // Short ETU keeps every count within a few hundred cycles.
        apb(1, `CETC_ADDR_ETU_DIV, 4);
        apb(1, `CETC_ADDR_RL_LOW, 3);
        apb(0, `CETC_ADDR_RL_LOW, 0); chk(r, 3);
        apb(1, `CETC_ADDR_MASK, 1);
        apb(1, `CETC_ADDR_CFG, 8'h05);
        wait_irq(); chk(n <= 16, 1);
        t = cyc;
        apb(0, `CETC_ADDR_STATUS, 0); chk(r & 8'h33, 8'h11);
        wait_irq(); chk(cyc - t inside {[11:13]}, 1);
        apb(1, `CETC_ADDR_MASK, 0);
        repeat (30) @(posedge i_mclk);
        chk(o_irq, 0);
        apb(1, `CETC_ADDR_CFG, 0);
        apb(0, `CETC_ADDR_STATUS, 0);
        repeat (40) @(posedge i_mclk);
        apb(0, `CETC_ADDR_STATUS, 0); chk(r, 0);
        $display("auto-reload test done");
        apb(1, `CETC_ADDR_RL_MID, 6);
        apb(1, `CETC_ADDR_MASK, 2);
        apb(1, `CETC_ADDR_CFG, 8'h71);
        repeat (20) @(posedge i_mclk);
        chk(o_irq, 0);
        fork cetc_card_model_i.frame(4, 1'b1, 8'hA5); join_none
        t = cyc;
        apb(1, `CETC_ADDR_RL_MID, 12);
        wait_irq(); chk(cyc - t inside {[23:28]}, 1);
        apb(0, `CETC_ADDR_STATUS, 0); chk(r & 3, 2);
        wait fork;
        @(posedge i_mclk);
        fork cetc_card_model_i.frame(4, 1'b0, 8'h3C); join_none
        t = cyc;
        wait_irq(); chk(cyc - t inside {[47:52]}, 1);
        wait fork;
        $display("retrigger test done");
        apb(1, `CETC_ADDR_RL_LOW, 20);
        foreach (codes[i]) begin
            mid = (codes[i] == 8'h7C) ? 0 : 20;
            apb(1, `CETC_ADDR_RL_MID, mid);
            apb(1, `CETC_ADDR_CFG, 0);
            apb(0, `CETC_ADDR_STATUS, 0);
            apb(1, `CETC_ADDR_CFG, codes[i]);
            fork cetc_card_model_i.frame(4, 1'b0, 8'h5A); join_none
            repeat (124) @(posedge i_mclk);
            apb(0, `CETC_ADDR_STATUS, 0);
            v = model(codes[i], 20, mid);
            chk(r & 3, v);
            wait fork;
        end
        $display("mode table test done");
        test_done();
    end
endmodule // cetc_top_tb
